// >>> design/cpc_pkg.sv
package cpc_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] IDX_POWER = 16'h1058;
  localparam logic [15:0] IDX_CLKCV = 16'h1059;
  localparam logic [15:0] IDX_HPLVL = 16'h105a;
  localparam logic [15:0] IDX_DCHOP = 16'h110d;
  localparam logic [15:0] IDX_HCHOP = 16'h1113;

  localparam logic [15:0] RST_POWER = 16'h0000;
  localparam logic [15:0] RST_CLKCV = 16'h0000;
  localparam logic [15:0] RST_HPLVL = 16'h0000;
  localparam logic [15:0] RST_DCHOP = 16'h0000;
  localparam logic [15:0] RST_HCHOP = 16'h0000;

  // Writable bit masks; all other bits are read-only or reserved.
  localparam logic [15:0] WMASK_POWER = 16'hffff;
  localparam logic [15:0] WMASK_CLKCV = 16'h017f;
  localparam logic [15:0] WMASK_HPLVL = 16'h009f;
  localparam logic [15:0] WMASK_DCHOP = 16'h0010;
  localparam logic [15:0] WMASK_HCHOP = 16'h0001;

  // Fixed read pattern of bits 12:9 of the clock and converter register.
  localparam logic [15:0] FIXED_CLKCV = 16'h1e00;

  localparam int unsigned POS_MUX_EN   = 8;
  localparam int unsigned POS_LOCKED   = 7;
  localparam int unsigned POS_MCLK_EN  = 6;
  localparam int unsigned POS_MCLK_SEL = 3;
  localparam int unsigned POS_PLL_SEL  = 1;
  localparam int unsigned POS_PLL_EN   = 0;
  localparam int unsigned POS_HP_MUTE  = 7;
  localparam int unsigned POS_HP_ATT   = 0;
  localparam int unsigned POS_DCHOP    = 4;
  localparam int unsigned POS_HCHOP    = 0;

  typedef enum logic [1:0] {
    CPC_MCLK_OFF,
    CPC_MCLK_ENGINE,
    CPC_MCLK_CONV
  } cpc_mclk_src_t;

  typedef struct packed {
    logic        pll;
    logic        ref_buffer;
    logic        adc;
    logic [3:0]  analog_out_pair;
    logic        aux_two_out_right;
    logic        aux_two_out_left;
    logic        aux_one_headphone_out_right;
    logic        aux_one_headphone_out_left;
    logic        hp_amp_right;
    logic        hp_amp_left;
    logic        rate_converter;
    logic        conv_engine;
    logic        audio_processor;
  } cpc_power_t;

  typedef struct packed {
    logic          hp_mute;
    logic [4:0]    hp_atten;
    logic          rate_converter_mux_en;
    logic          master_clock_out_pin_en;
    cpc_mclk_src_t master_clock_out_src;
    logic [1:0]    pll_mult_sel;
    logic          pll_in_use;
    logic          dac_amp_chop_off;
    logic          hp_amp_chop_off;
  } cpc_ctrl_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic [15:0] wdata;
  } cpc_req_t;

endpackage : cpc_pkg

// >>> design/cpc_sync.sv
`timescale 1ns/100ps
module cpc_sync
  import cpc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic first;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first    <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      first    <= async_in;
      sync_out <= first;
    end
  end

endmodule : cpc_sync

// >>> design/cpc_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Each power bit turns its block on at 1 and off at 0, PLL at bit 15 down to the processor at bit 0.
// - The power register resets to zero with converter pairs at 12:9, headphone sides at 4:3, converter at 2.
// - Headphone level bit 7 mutes the headphone amplifier when set.
// - Headphone level bits 4:0 give attenuation in 1.5 dB steps and reset to zero.
// - Bits 12:9 of the clock register always read 1111 and software writes them as zero.
// - Clock register bit 8 enables the rate converter input mux.
// - Clock register bit 7 is read-only and shows the rate converter lock state.
// - Clock register bit 6 enables the master clock output pin.
// - Clock register bits 5:3 pick the pin source: 001 engine clock, 1xx converter clock, others reserved.
// - Clock register bits 2:1 pick PLL output of 64, 128, 256 or 512 times the sample rate.
// - Clock register bit 0 bypasses the PLL at 0 and uses it at 1.
// - DAC amplifier bit 4 disables chopping at 1 and resets to 0.
// - Headphone amplifier bit 0 disables chopping at 1 and resets to 0.
module cpc_regs
  import cpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rate_converter_locked,
  output cpc_power_t       power_en,
  output cpc_ctrl_t        ctrl
);

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] st, input logic [15:0] mask);
    logic [15:0] lane;
    lane  = {{8{st[1]}}, {8{st[0]}}};
    merge = (old & ~(lane & mask)) | (wd & lane & mask);
  endfunction : merge

  logic [15:0] reg_power;
  logic [15:0] reg_clkcv;
  logic [15:0] reg_hplvl;
  logic [15:0] reg_dchop;
  logic [15:0] reg_hchop;
  logic        locked_sync;
  logic [15:0] rd_val;

  cpc_sync u_lock_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (rate_converter_locked),
    .sync_out (locked_sync)
  );

  cpc_req_t req;
  assign req = '{addr: paddr[17:2], write: pwrite, wdata: pwdata[15:0]};

  wire         word_ok  = (paddr[1:0] == 2'h0);
  wire         hit_pw   = word_ok && (req.addr == IDX_POWER);
  wire         hit_cc   = word_ok && (req.addr == IDX_CLKCV);
  wire         hit_hl   = word_ok && (req.addr == IDX_HPLVL);
  wire         hit_dc   = word_ok && (req.addr == IDX_DCHOP);
  wire         hit_hc   = word_ok && (req.addr == IDX_HCHOP);
  wire         hit_any  = hit_pw | hit_cc | hit_hl | hit_dc | hit_hc;
  wire         access   = psel && penable;
  wire         wr_go    = access && req.write && hit_any;
  wire [1:0]   st       = pstrb[1:0];

  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;

  // Writes land at the access edge; the outputs follow the registers directly, with no extra cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_power <= RST_POWER;
      reg_clkcv <= RST_CLKCV;
      reg_hplvl <= RST_HPLVL;
      reg_dchop <= RST_DCHOP;
      reg_hchop <= RST_HCHOP;
    end else if (wr_go) begin
      if (hit_pw) reg_power <= merge(reg_power, req.wdata, st, WMASK_POWER);
      if (hit_cc) reg_clkcv <= merge(reg_clkcv, req.wdata, st, WMASK_CLKCV);
      if (hit_hl) reg_hplvl <= merge(reg_hplvl, req.wdata, st, WMASK_HPLVL);
      if (hit_dc) reg_dchop <= merge(reg_dchop, req.wdata, st, WMASK_DCHOP);
      if (hit_hc) reg_hchop <= merge(reg_hchop, req.wdata, st, WMASK_HCHOP);
    end
  end

  // Read view: lock status inserted after the two-flop synchroniser, fixed pattern forced high.
  wire [15:0] clkcv_view = reg_clkcv | FIXED_CLKCV
                         | (16'(locked_sync) << POS_LOCKED);

  assign rd_val = hit_pw ? reg_power :
                  hit_cc ? clkcv_view :
                  hit_hl ? reg_hplvl :
                  hit_dc ? reg_dchop :
                  hit_hc ? reg_hchop : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_val};
    end
  end

  assign power_en = cpc_power_t'(reg_power);

  wire [2:0] src_code = reg_clkcv[POS_MCLK_SEL +: 3];
  wire       src_conv = src_code[2];
  wire       src_eng  = (src_code == 3'h1);

  cpc_mclk_src_t src_sel;
  assign src_sel = src_conv ? CPC_MCLK_CONV :
                   src_eng  ? CPC_MCLK_ENGINE : CPC_MCLK_OFF;

  // One driver for the whole control bundle.
  assign ctrl = '{
    hp_mute:                 reg_hplvl[POS_HP_MUTE],
    hp_atten:                reg_hplvl[POS_HP_ATT +: 5],
    rate_converter_mux_en:   reg_clkcv[POS_MUX_EN],
    master_clock_out_pin_en: reg_clkcv[POS_MCLK_EN],
    master_clock_out_src:    src_sel,
    pll_mult_sel:            reg_clkcv[POS_PLL_SEL +: 2],
    pll_in_use:              reg_clkcv[POS_PLL_EN],
    dac_amp_chop_off:        reg_dchop[POS_DCHOP],
    hp_amp_chop_off:         reg_hchop[POS_HCHOP]
  };

endmodule : cpc_regs

// >>> bench/cpc_regs_chk.sv
`timescale 1ns/100ps
module cpc_regs_chk
  import cpc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rate_converter_locked,
  input wire cpc_power_t  power_en,
  input wire cpc_ctrl_t   ctrl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr    = psel & penable & pwrite & (&pstrb[1:0]);
  wire       wr_pw = wr & (paddr == 18'h04160);
  wire       wr_cv = wr & (paddr == 18'h04164);
  wire       wr_hl = wr & (paddr == 18'h04168);
  wire       rd_cv = psel & penable & !pwrite & (paddr == 18'h04164);
  wire [1:0] src_exp = pwdata[5] ? CPC_MCLK_CONV
                     : (pwdata[4:3] == 2'b01) ? CPC_MCLK_ENGINE : CPC_MCLK_OFF;
  sequence lock_held; rate_converter_locked [*5] ##0 rd_cv; endsequence
  a_reset_off: assert property ($rose(presetn) |-> power_en == '0 && ctrl == '0)
    else $error("outputs not clear after reset");
  a_power_mirror: assert property (wr_pw |=> power_en == $past(pwdata[15:0]))
    else $error("power outputs differ from write");
  a_hp_atten: assert property (wr_hl |=> ctrl.hp_atten == $past(pwdata[4:0]))
    else $error("attenuation differs from write");
  a_fixed_bits: assert property (rd_cv |-> prdata[12:9] == 4'hf)
    else $error("fixed pattern missing");
  a_lock_read: assert property (lock_held |-> prdata[7])
    else $error("lock bit not shown");
  a_mux_enable: assert property (wr_cv |=> ctrl.rate_converter_mux_en == $past(pwdata[8]))
    else $error("mux enable differs from write");
  a_src_decode: assert property (wr_cv |=> ctrl.master_clock_out_src == $past(src_exp))
    else $error("clock source decode wrong");
  a_pll_control: assert property (wr_cv |=> ctrl[4:2] == $past(pwdata[2:0]))
    else $error("pll controls differ from write");
endmodule : cpc_regs_chk
bind cpc_regs cpc_regs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .rate_converter_locked, .power_en, .ctrl);

// >>> bench/cpc_regs_test.sv
`timescale 1ns/100ps
module cpc_regs_test
  import cpc_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        rate_converter_locked = 1'b0, pready, pslverr, err;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [17:0] paddr = '0;
  logic [3:0]  pstrb = 4'hf;
  cpc_power_t  power_en;
  cpc_ctrl_t   ctrl;
  int          n_fail = 0, n_tests = 0;
  localparam logic [17:0] ADR [5] = '{18'h04160, 18'h04164, 18'h04168, 18'h04434, 18'h0444c};
  localparam logic [31:0] MSK [5] = '{32'hffff, 32'h1fff, 32'h009f, 32'h0010, 32'h0001};
  always #25 pclk = ~pclk;
  cpc_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .rate_converter_locked, .power_en, .ctrl);
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) n_fail++;
    if (got !== exp) $display("Error %s expected %h seen %h", name, exp, got);
  endtask : chk
  task apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask : apb
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    {presetn, rate_converter_locked} <= 2'b11;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ADR[i], 32'h0);
      chk("reset read", (i == 1) ? 32'h1e80 : 32'h0, rd);
      apb(1'b1, ADR[i], 32'hffffffff);
      apb(1'b0, ADR[i], 32'h0);
      chk("mask read", MSK[i], rd);
    end
    chk("power out", 32'hffff, 32'(power_en));
    chk("ctrl out", 32'h7fdf, 32'(ctrl));
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 18'h04164, 32'(s * 9));
      chk("src", 32'((s > 3) ? CPC_MCLK_CONV : (s == 1) ? CPC_MCLK_ENGINE : CPC_MCLK_OFF),
        32'(ctrl.master_clock_out_src));
      chk("pll", 32'(s), 32'({ctrl.pll_mult_sel, ctrl.pll_in_use}));
    end
    apb(1'b0, 18'h04164, 32'h0);
    chk("lock held", 32'h1ebf, rd);
    @(posedge pclk);
    rate_converter_locked <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, 18'h04164, 32'h0);
    chk("lock clear", 32'h1e3f, rd);
    apb(1'b0, 18'h04000, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1'b1, 18'h04160, 32'h0);
    @(posedge pclk);
    pstrb <= 4'hf;
    apb(1'b0, 18'h04160, 32'h0);
    chk("lane write", 32'hff00, rd);
    $display("register tests done");
    stop_test();
  end
endmodule : cpc_regs_test
